// *** verilog/fhc_engine.sv ***
/*
 * Flash halt check engine: on a halt while armed, reads code flash from
 * address zero one word per clock and accumulates a CRC-16 in the result
 * register, then releases the halt.
 * Assumes the CPU bus, halt strobe and flash port are on clk; flash data
 * returns one clock after the read request, and the flash read port stalls
 * with the same clock enable, so a frozen cycle never loses a word.
 * Assumes the seed is preset by a result write while armed; prohibited
 * range codes leave a halt as a plain halt with no check.
 * Words fold one clock after they are read, so the release comes two
 * clocks after the last read.
 * The hold output keeps the CPU stopped; the release pulse wakes it.
 */
// Contract
// - CRC-16-CCITT polynomial, taps twelve, five, zero
// - Words fed MSB first, bit 31 to 0
// - Armed halt starts the flash check
// - Unarmed: engine idle, halt checks nothing
// - Release halt automatically when check completes
// - Range code selects (code+1) times 16 KB
// - Start at zero, skip last four bytes
// - One clock per checked 32-bit word
// - Final checksum lands in result register
// - Result writes only while armed
// - Control: byte or arm-bit access; bit six zero
// - CPU stays stopped during whole check
`timescale 1ns/1ps
`default_nettype none
module fhc_engine
	import fhc_pkg::*;
#(
	parameter int STEP_WORDS = FHC_STEP_WORDS
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire fhc_bus_req_s bus_req,
	output logic [15:0] bus_rdata,
	input wire logic halt_exec,
	output logic cpu_hold,
	output logic halt_release,
	output fhc_flash_req_s flash_req,
	input wire logic [31:0] flash_rdata
);
	// One-hot sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RUN = 3'b010,
		ST_DRAIN = 3'b100
	} fhc_state_e;

	fhc_state_e state_q, state_d;
	logic [7:0] ctrl_q, ctrl_d;
	logic [15:0] result_q, result_d;
	logic [FHC_FADDR_W-1:0] addr_q, addr_d;
	logic [FHC_FADDR_W-1:0] last_q, last_d;
	logic data_vld_q;
	logic hold_q;
	logic release_q;
	logic rd_q;
	logic [15:0] rdata_q, rdata_d;
	logic [15:0] crc_next;

	// Write strobe for one register at one access size
	function automatic logic wr_hit(input fhc_bus_req_s r, input logic [19:0] a,
		input fhc_size_e s);
		wr_hit = r.wr && r.addr == a && r.size == s;
	endfunction

	// Read strobe for one register, access size ignored
	function automatic logic rd_hit(input fhc_bus_req_s r, input logic [19:0] a);
		rd_hit = r.rd && r.addr == a;
	endfunction

	// Register decode
	wire arm = ctrl_q[FHC_ARM_POS];
	wire [5:0] range_code = ctrl_q[FHC_RANGE_LSB +: FHC_RANGE_W];
	wire ctrl_rd = rd_hit(bus_req, FHC_CTRL_ADDR);
	wire result_rd = rd_hit(bus_req, FHC_RESULT_ADDR);
	// Control takes a whole byte or the arm bit alone
	wire ctrl_byte_wr = wr_hit(bus_req, FHC_CTRL_ADDR, FHC_SZ_BYTE);
	wire ctrl_bit_wr = wr_hit(bus_req, FHC_CTRL_ADDR, FHC_SZ_BIT) &&
		bus_req.bit_pos == 3'(FHC_ARM_POS);
	// Result takes a word write only while armed and idle
	wire result_wr = wr_hit(bus_req, FHC_RESULT_ADDR, FHC_SZ_WORD) && arm &&
		state_q == ST_IDLE;
	// Prohibited range codes never start a check
	wire range_ok = range_code <= FHC_RANGE_MAX;
	// A halt starts a check only when armed, legal and idle
	wire start = halt_exec && arm && range_ok && state_q == ST_IDLE;
	// Final word index reached
	wire at_last = addr_q == last_q;

	// Last word index: (code+1) steps of words less the final word
	// Top range wraps to zero; the subtraction still gives the right index
	wire [FHC_FADDR_W-1:0] range_words =
		FHC_FADDR_W'((32'(range_code) + 32'd1) * 32'(STEP_WORDS));
	wire [FHC_FADDR_W-1:0] range_last = range_words - FHC_FADDR_W'(2);

	// Word-wide CRC step
	fhc_crc_word u_crc (
		.crc_in(result_q),
		.word_in(flash_rdata),
		.crc_out(crc_next)
	);

	// Control register next value
	always_comb begin
		ctrl_d = ctrl_q;
		if (ctrl_byte_wr) begin
			ctrl_d = bus_req.wdata[7:0];
		end else if (ctrl_bit_wr) begin
			ctrl_d[FHC_ARM_POS] = bus_req.wdata[0];
		end
		// Bit six forced low whatever is written
		ctrl_d[FHC_ZERO_POS] = 1'b0;
	end

	// Sequencer
	always_comb begin
		state_d = state_q;
		addr_d = addr_q;
		last_d = last_q;
		unique case (state_q)
			ST_IDLE: begin
				if (start) begin
					state_d = ST_RUN;
					addr_d = '0;
					last_d = range_last;
				end
			end
			ST_RUN: begin
				// One word per clock until the last index
				addr_d = addr_q + FHC_FADDR_W'(1);
				if (at_last) begin
					state_d = ST_DRAIN;
				end
			end
			ST_DRAIN: begin
				// Last word folds while the release is registered
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Result register: CRC accumulation, else CPU write while armed
	always_comb begin
		result_d = result_q;
		if (data_vld_q) begin
			result_d = crc_next;
		end else if (result_wr) begin
			result_d = bus_req.wdata;
		end
	end

	// Read data mux, control bit six always zero
	always_comb begin
		rdata_d = 16'h0000;
		if (ctrl_rd) begin
			rdata_d = {8'h00, ctrl_q};
		end else if (result_rd) begin
			rdata_d = result_q;
		end
	end

	// State and registers
	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= ST_IDLE;
			ctrl_q <= FHC_CTRL_RESET;
			result_q <= FHC_RESULT_RESET;
			addr_q <= '0;
			last_q <= '0;
			rdata_q <= 16'h0000;
		end else if (ce) begin
			state_q <= state_d;
			ctrl_q <= ctrl_d;
			result_q <= result_d;
			addr_q <= addr_d;
			last_q <= last_d;
			rdata_q <= rdata_d;
		end
	end

	// Data-valid, hold and release pipeline
	// Hold drops in the same cycle as the release pulse
	always_ff @(posedge clk) begin
		if (reset) begin
			data_vld_q <= 1'b0;
			hold_q <= 1'b0;
			release_q <= 1'b0;
		end else if (ce) begin
			data_vld_q <= state_q == ST_RUN;
			hold_q <= state_d != ST_IDLE;
			release_q <= state_q == ST_DRAIN;
		end
	end

	// Flash read strobe, registered from the next state so the port sees a flop
	always_ff @(posedge clk) begin
		if (reset) begin
			rd_q <= 1'b0;
		end else if (ce) begin
			rd_q <= state_d == ST_RUN;
		end
	end

	// Outputs straight from flip-flops
	assign bus_rdata = rdata_q;
	assign cpu_hold = hold_q;
	assign halt_release = release_q;
	assign flash_req.rd = rd_q;
	assign flash_req.word_addr = addr_q;
endmodule
`default_nettype wire

// *** verilog/fhc_pkg.sv ***
/*
 * Shared constants and carrier types of the flash halt check engine.
 * Assumes a 20-bit CPU data address space and a 32-bit code flash read port.
 */
package fhc_pkg;
	// Register addresses
	localparam logic [19:0] FHC_CTRL_ADDR = 20'hF02F0;
	localparam logic [19:0] FHC_RESULT_ADDR = 20'hF02F2;
	// Control register fields and reset
	localparam int FHC_ARM_POS = 7;
	localparam int FHC_ZERO_POS = 6;
	localparam int FHC_RANGE_LSB = 0;
	localparam int FHC_RANGE_W = 6;
	localparam logic [7:0] FHC_CTRL_RESET = 8'h00;
	localparam logic [5:0] FHC_RANGE_MAX = 6'h1F;
	// Result register reset
	localparam logic [15:0] FHC_RESULT_RESET = 16'h0000;
	// CRC-16-CCITT generator, taps at 12 and 5 plus constant term
	localparam logic [15:0] FHC_CRC_POLY = 16'h1021;
	localparam int FHC_WORD_BITS = 32;
	// Range step and flash word size
	localparam int FHC_STEP_BYTES = 16384;
	localparam int FHC_WORD_BYTES = 4;
	localparam int FHC_STEP_WORDS = FHC_STEP_BYTES / FHC_WORD_BYTES;
	// Clocks for the smallest range; each step adds one step of words
	localparam int FHC_BASE_CLOCKS = 4095;
	localparam int FHC_FADDR_W = 17;

	// Access size of a CPU register access
	typedef enum logic [1:0] {
		FHC_SZ_BIT = 2'h0,
		FHC_SZ_BYTE = 2'h1,
		FHC_SZ_WORD = 2'h2
	} fhc_size_e;

	// One CPU register access, valid for one cycle
	typedef struct packed {
		logic [19:0] addr;
		logic wr;
		logic rd;
		fhc_size_e size;
		logic [2:0] bit_pos;
		logic [15:0] wdata;
	} fhc_bus_req_s;

	// Flash read request toward the code flash
	typedef struct packed {
		logic rd;
		logic [FHC_FADDR_W-1:0] word_addr;
	} fhc_flash_req_s;
endpackage

// *** verilog/fhc_crc_word.sv ***
/*
 * Folds one 32-bit word into a CRC-16 value, most significant bit first.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/1ps
`default_nettype none
module fhc_crc_word
	import fhc_pkg::*;
(
	input wire logic [15:0] crc_in,
	input wire logic [31:0] word_in,
	output logic [15:0] crc_out
);
	// One shift of the serial CRC register
	function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic d);
		logic fb;
		fb = c[15] ^ d;
		crc_bit = {c[14:0], 1'b0} ^ (fb ? FHC_CRC_POLY : 16'h0000);
	endfunction

	// Bit 31 first down to bit 0
	always_comb begin
		logic [15:0] c;
		c = crc_in;
		for (int i = FHC_WORD_BITS - 1; i >= 0; i--) begin
			c = crc_bit(c, word_in[i]);
		end
		crc_out = c;
	end
endmodule
`default_nettype wire

// *** verif/fhc_engine_chk.sv ***
/* Port assertions of the check engine.
   Bound to fhc_engine below. */
`timescale 1ns/1ps
`default_nettype none
module fhc_engine_chk
	import fhc_pkg::*;
#(parameter int STEP_WORDS = FHC_STEP_WORDS)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic cpu_hold,
	input wire logic halt_release,
	input wire fhc_flash_req_s flash_req
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Check timing and read addresses
	sequence s_end; !flash_req.rd ##1 halt_release; endsequence
	property p_tail; $fell(flash_req.rd) && ce |-> s_end; endproperty
	property p_pulse; halt_release && ce |=> !halt_release; endproperty
	property p_drop; halt_release |-> !cpu_hold; endproperty
	property p_held; $rose(halt_release) |-> $past(cpu_hold); endproperty
	property p_rdh; flash_req.rd |-> cpu_hold; endproperty
	property p_zero; $rose(flash_req.rd) |-> flash_req.word_addr == 0; endproperty
	property p_step;
		flash_req.rd && $past(flash_req.rd) && $past(ce) |->
			flash_req.word_addr == $past(flash_req.word_addr) + 1;
	endproperty
	property p_cap; flash_req.rd |-> flash_req.word_addr < 32 * STEP_WORDS - 1; endproperty
	a_tail: assert property (p_tail) else $error("no release after reads");
	a_pulse: assert property (p_pulse) else $error("release too long");
	a_drop: assert property (p_drop) else $error("hold at release");
	a_held: assert property (p_held) else $error("release without hold");
	a_rdh: assert property (p_rdh) else $error("read while idle");
	a_zero: assert property (p_zero) else $error("first word not zero");
	a_step: assert property (p_step) else $error("address skip");
	a_cap: assert property (p_cap) else $error("address past range");
endmodule
bind fhc_engine fhc_engine_chk #(.STEP_WORDS(STEP_WORDS)) u_chk(.clk(clk), .reset(reset),
	.ce(ce), .cpu_hold(cpu_hold), .halt_release(halt_release), .flash_req(flash_req));
`default_nettype wire

// *** verif/fhc_flash_model.sv ***
/* Code flash model: one word a clock after each read.
   Assumes requests on clk. */
`timescale 1ns/1ps
`default_nettype none
module fhc_flash_model
	import fhc_pkg::*;
(
	input wire logic clk,
	input wire logic ce,
	input wire fhc_flash_req_s req,
	output logic [31:0] rdata = 32'h0
);
	// Content from address
	function automatic logic [31:0] word_of(input logic [16:0] a);
		return {~a[15:0], a[15:0] ^ 16'hC35A};
	endfunction
	// Data after read, toggling otherwise; stalls with the clock enable
	always @(posedge clk) begin
		if (ce) begin
			rdata <= req.rd ? word_of(req.word_addr) : ~rdata;
		end
	end
endmodule
`default_nettype wire

// *** verif/flash_halt_crc_engine_tb_top.sv ***
/* Bench of the check engine.
   Uses a step of 4 words and the flash model. */
`timescale 1ns/1ps
`default_nettype none
module flash_halt_crc_engine_tb_top;
	import fhc_pkg::*;
	localparam int SW = 4;
	logic clk = 1'b0;
	logic reset = 1'b1;
	fhc_bus_req_s bus_req = '0;
	logic halt_exec = 1'b0;
	logic ce = 1'b1;
	logic [15:0] bus_rdata;
	logic cpu_hold;
	logic halt_release;
	fhc_flash_req_s flash_req;
	logic [31:0] flash_rdata;
	int err_count = 0;
	int checks = 0;
	fhc_engine #(.STEP_WORDS(SW)) uut(.clk(clk), .reset(reset), .ce(ce), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .halt_exec(halt_exec), .cpu_hold(cpu_hold),
		.halt_release(halt_release), .flash_req(flash_req), .flash_rdata(flash_rdata));
	fhc_flash_model u_flash(.clk(clk), .ce(ce), .req(flash_req), .rdata(flash_rdata));
	// Clock
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	// One register access
	task automatic acc(input logic [19:0] a, input logic w, input fhc_size_e s, input logic [15:0] d);
		@(posedge clk);
		bus_req <= '{a, w, !w, s, 3'h7, d};
		@(posedge clk);
		bus_req <= '0;
		#1;
	endtask
	task automatic rd(input logic [19:0] a, input fhc_size_e s, input string n, input logic [15:0] e);
		acc(a, 1'b0, s, 16'h0);
		cmp(n, e, bus_rdata);
	endtask
	// Expected CRC over nw words
	function automatic logic [15:0] crc_of(input logic [15:0] c, input int nw);
		logic [31:0] w;
		for (int k = 0; k < nw; k++) begin
			w = u_flash.word_of(17'(k));
			for (int i = 31; i >= 0; i--) begin
				c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? FHC_CRC_POLY : 16'h0);
			end
		end
		return c;
	endfunction
	// Halt pulse, count clocks to release; enable frozen for frz clocks
	task automatic run(input int n_exp, input int frz);
		int n;
		@(posedge clk);
		halt_exec <= 1'b1;
		@(posedge clk);
		halt_exec <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			ce <= !(n >= 1 && n <= frz);
			#1;
			n++;
			if (n == 1) begin
				cmp("hold", 16'(n_exp < 40), 16'(cpu_hold));
			end
		end while (halt_release !== 1'b1 && n < 40);
		cmp("clocks", 16'(n_exp), 16'(n));
		if (n_exp < 40 && n >= 40) wrap_up();
	endtask
	task automatic t_regs;
		rd(FHC_CTRL_ADDR, FHC_SZ_BYTE, "ctrl", 16'h0);
		acc(FHC_RESULT_ADDR, 1'b1, FHC_SZ_WORD, 16'h1234);
		rd(FHC_RESULT_ADDR, FHC_SZ_WORD, "result", 16'h0);
		acc(FHC_CTRL_ADDR, 1'b1, FHC_SZ_BYTE, 16'h00FF);
		rd(FHC_CTRL_ADDR, FHC_SZ_BYTE, "ctrl", 16'h00BF);
		acc(FHC_CTRL_ADDR, 1'b1, FHC_SZ_BIT, 16'h0);
		rd(FHC_CTRL_ADDR, FHC_SZ_BYTE, "arm", 16'h003F);
		run(40, 0);
	endtask
	task automatic t_check(input logic [5:0] code, input logic [15:0] seed, input int frz);
		int nw;
		nw = (code + 1) * SW - 1;
		acc(FHC_CTRL_ADDR, 1'b1, FHC_SZ_BYTE, {8'h0, 2'b10, code});
		acc(FHC_RESULT_ADDR, 1'b1, FHC_SZ_WORD, seed);
		run(nw + 1 + frz, frz);
		rd(FHC_RESULT_ADDR, FHC_SZ_WORD, "crc", crc_of(seed, nw));
	endtask
	task automatic t_bad;
		acc(FHC_CTRL_ADDR, 1'b1, FHC_SZ_BYTE, 16'h00A0);
		acc(FHC_RESULT_ADDR, 1'b1, FHC_SZ_WORD, 16'h5555);
		run(40, 0);
		rd(FHC_RESULT_ADDR, FHC_SZ_WORD, "kept", 16'h5555);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		t_regs();
		t_check(6'h00, 16'hFFFF, 0);
		t_check(6'h01, 16'h0000, 0);
		t_check(6'h01, 16'hA5C3, 5);
		t_bad();
		wrap_up();
	end
endmodule
`default_nettype wire
